// ### core/adc_ctl_consts.svh
`ifndef ADC_CTL_CONSTS_SVH
`define ADC_CTL_CONSTS_SVH

// register offsets
`define ADDR_W                13
`define OFS_USER_PAT2_LOW     13'h001B
`define OFS_USER_PAT2_HIGH    13'h001C
`define OFS_SIGNATURE_LOW     13'h0024
`define OFS_OVERRANGE_OE      13'h002A
`define OFS_CHAN_SOURCE       13'h002E
`define OFS_DIV_SYNC_CTL      13'h0100
`define OFS_MISC_USER_CTL     13'h0101

// field positions
`define SYNC_MASTER_BIT       0
`define SYNC_DIV_EN_BIT       1
`define SYNC_NEXT_ONLY_BIT    2
`define MISC_PD_DIS_BIT       0
`define MISC_RUN_OSC_BIT      2
`define MISC_DETECT_EN_BIT    3
`define MISC_OE_PIN_CTL_BIT   7

// reset values
`define RST_USER_PAT          8'h00
`define RST_OVERRANGE_OE      8'h01
`define RST_CHAN_SOURCE_A     8'h00
`define RST_CHAN_SOURCE_B     8'h01
`define RST_DIV_SYNC_CTL      8'h01
`define RST_MISC_USER_CTL     8'h88

// timing
`define CLK_PERIOD_NS         10
`define LR_WINDOW_NS          1000
`define LR_MIN_RATE_MSPS      5
`define LR_WINDOW_CYC         (`LR_WINDOW_NS / `CLK_PERIOD_NS)
`define LR_MIN_EDGES          (`LR_MIN_RATE_MSPS * `LR_WINDOW_NS / 1000)

`endif

// ### core/adc_ctl_pkg.sv
`default_nettype none
package adc_ctl_pkg;
    typedef logic [12:0] reg_addr_t;
    typedef logic [7:0]  reg_byte_t;
    typedef logic [1:0]  chan_mask_t;
endpackage
`default_nettype wire

// ### core/low_rate_detector.sv
`default_nettype none
`include "adc_ctl_consts.svh"
module low_rate_detector #(
    parameter int WINDOW_CYC = `LR_WINDOW_CYC,
    parameter int MIN_EDGES  = `LR_MIN_EDGES
) (
    input  wire logic sys_clk,      // system clock
    input  wire logic srst,         // sync reset
    input  wire logic enable,       // detector on
    input  wire logic enc_edge,     // one encode edge seen (same clock)
    output logic      low_rate_q    // encode rate under threshold
);
    logic [15:0] win_q;
    logic [15:0] edges_q;

    // window timer
    always_ff @(posedge sys_clk) begin
        if (srst || !enable || win_q == 16'(WINDOW_CYC - 1)) begin
            win_q <= 16'h0000;
        end else begin
            win_q <= win_q + 16'h0001;
        end
    end

    // edge counter, saturating
    always_ff @(posedge sys_clk) begin
        if (srst || !enable || win_q == 16'(WINDOW_CYC - 1)) begin
            edges_q <= 16'h0000;
        end else if (enc_edge && edges_q != 16'hFFFF) begin
            edges_q <= edges_q + 16'h0001;
        end
    end

    // verdict refreshed once per window; a stopped clock reads as low rate
    always_ff @(posedge sys_clk) begin
        if (srst || !enable) begin
            low_rate_q <= 1'b0;
        end else if (win_q == 16'(WINDOW_CYC - 1)) begin
            low_rate_q <= (edges_q < 16'(MIN_EDGES));
        end
    end
endmodule // low_rate_detector
`default_nettype wire

// ### core/adc_sync_misc_control_regs.sv
// Functional notes
// - no sync action at all unless master sync enable is one
// - divider sync enable gates sync pulses; continuous resync when next-only clear
// - with next-only set, divider aligns to first pulse and ignores later ones
// - after a one-shot sync, hardware clears the divider sync enable bit
// - output-enable pin controls outputs only while its control bit is one
// - detect bit enables low-rate monitor driving internal oscillator; clear disables it
// - run-oscillator bit forces the internal oscillator on regardless of detector
// - pull-down disable bit one switches off serial data pin pull-down
`default_nettype none
`include "adc_ctl_consts.svh"
module adc_sync_misc_control_regs (
    input  wire logic                   sys_clk,              // 100 MHz clock
    input  wire logic                   srst,                 // sync reset, high
    input  wire adc_ctl_pkg::reg_addr_t reg_addr,             // register address
    input  wire logic                   reg_wr,               // write strobe
    input  wire logic                   reg_rd,               // read strobe
    input  wire adc_ctl_pkg::reg_byte_t reg_wdata,            // write data
    input  wire adc_ctl_pkg::chan_mask_t chan_mask,           // indexed channels
    output adc_ctl_pkg::reg_byte_t      reg_rdata_q,          // read data
    output logic                        reg_rvalid_q,         // read data valid
    input  wire logic                   signature_bit,        // signature bit 0
    input  wire logic                   sync_pin,             // external sync, async
    input  wire logic                   output_enable_pin_n,  // output enable pin, async
    input  wire logic                   encode_tick,          // encode clock level, async
    output logic [15:0]                 user_pattern_two_q,   // user pattern 2
    output logic [1:0]                  overrange_oe_q,       // per channel OR pin enable
    output logic [1:0]                  chan_source_q,        // per channel ADC select
    output logic                        div_sync_pulse_q,     // sync to clock divider
    output logic                        data_out_enable_q,    // data output enable
    output logic                        osc_run_q,            // low_rate_internal_oscillator on
    output logic                        sdio_pulldown_en_q    // serial data pull-down on
);
    import adc_ctl_pkg::*;

    // reset words as typed constants: a bare sized literal cannot be bit-selected
    localparam reg_byte_t SYNC_RST  = `RST_DIV_SYNC_CTL;
    localparam reg_byte_t MISC_RST  = `RST_MISC_USER_CTL;
    localparam reg_byte_t ORA_RST   = `RST_OVERRANGE_OE;
    localparam reg_byte_t SRC_RST_A = `RST_CHAN_SOURCE_A;
    localparam reg_byte_t SRC_RST_B = `RST_CHAN_SOURCE_B;

    logic       master_q, div_en_q, next_only_q;
    logic       oe_pin_ctl_q, detect_en_q, run_osc_q, pd_dis_q;
    logic [2:0] sync_sr_q;
    logic [1:0] oe_sr_q;
    logic [2:0] enc_sr_q;
    logic       low_rate_q;
    logic       sync_edge, enc_edge, sync_wr, misc_wr, sync_fire;
    reg_addr_t  rd_addr_q;

    assign sync_wr   = reg_wr && reg_addr == `OFS_DIV_SYNC_CTL;
    assign misc_wr   = reg_wr && reg_addr == `OFS_MISC_USER_CTL;
    // stage 0 of each synchroniser feeds only stage 1
    assign sync_edge = sync_sr_q[1] && !sync_sr_q[2];
    assign enc_edge  = enc_sr_q[1] && !enc_sr_q[2];
    assign sync_fire = sync_edge && master_q && div_en_q;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sync_sr_q <= 3'h0;
            oe_sr_q   <= 2'h3;
            enc_sr_q  <= 3'h0;
        end else begin
            sync_sr_q <= {sync_sr_q[1:0], sync_pin};
            oe_sr_q   <= {oe_sr_q[0], output_enable_pin_n};
            enc_sr_q  <= {enc_sr_q[1:0], encode_tick};
        end
    end

    // user pattern and per-channel registers
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            user_pattern_two_q <= {`RST_USER_PAT, `RST_USER_PAT};
            overrange_oe_q     <= {2{ORA_RST[0]}};
            chan_source_q      <= {SRC_RST_B[0], SRC_RST_A[0]};
        end else if (reg_wr) begin
            if (reg_addr == `OFS_USER_PAT2_LOW) user_pattern_two_q[7:0] <= reg_wdata;
            if (reg_addr == `OFS_USER_PAT2_HIGH) user_pattern_two_q[15:8] <= reg_wdata;
            for (int c = 0; c < 2; c++) begin
                if (chan_mask[c] && reg_addr == `OFS_OVERRANGE_OE)
                    overrange_oe_q[c] <= reg_wdata[0];
                if (chan_mask[c] && reg_addr == `OFS_CHAN_SOURCE)
                    chan_source_q[c] <= reg_wdata[0];
            end
        end
    end

    // sync control; a host write in the clearing cycle wins, so it is never lost
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            master_q    <= SYNC_RST[`SYNC_MASTER_BIT];
            div_en_q    <= SYNC_RST[`SYNC_DIV_EN_BIT];
            next_only_q <= SYNC_RST[`SYNC_NEXT_ONLY_BIT];
        end else if (sync_wr) begin
            master_q    <= reg_wdata[`SYNC_MASTER_BIT];
            div_en_q    <= reg_wdata[`SYNC_DIV_EN_BIT];
            next_only_q <= reg_wdata[`SYNC_NEXT_ONLY_BIT];
        end else if (sync_fire && next_only_q) begin
            div_en_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) div_sync_pulse_q <= 1'b0;
        else div_sync_pulse_q <= sync_fire;
    end

    // misc user control
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            oe_pin_ctl_q <= MISC_RST[`MISC_OE_PIN_CTL_BIT];
            detect_en_q  <= MISC_RST[`MISC_DETECT_EN_BIT];
            run_osc_q    <= MISC_RST[`MISC_RUN_OSC_BIT];
            pd_dis_q     <= MISC_RST[`MISC_PD_DIS_BIT];
        end else if (misc_wr) begin
            oe_pin_ctl_q <= reg_wdata[`MISC_OE_PIN_CTL_BIT];
            detect_en_q  <= reg_wdata[`MISC_DETECT_EN_BIT];
            run_osc_q    <= reg_wdata[`MISC_RUN_OSC_BIT];
            pd_dis_q     <= reg_wdata[`MISC_PD_DIS_BIT];
        end
    end

    low_rate_detector u_detect (
        .sys_clk    (sys_clk),
        .srst       (srst),
        .enable     (detect_en_q),
        .enc_edge   (enc_edge),
        .low_rate_q (low_rate_q)
    );

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            data_out_enable_q  <= 1'b1;
            osc_run_q          <= 1'b0;
            sdio_pulldown_en_q <= 1'b1;
        end else begin
            data_out_enable_q  <= oe_pin_ctl_q ? !oe_sr_q[1] : 1'b1;
            osc_run_q          <= run_osc_q || (detect_en_q && low_rate_q);
            sdio_pulldown_en_q <= !pd_dis_q;
        end
    end

    // read port: one cycle latency, unmapped and open bits read zero
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            reg_rdata_q  <= 8'h00;
            reg_rvalid_q <= 1'b0;
            rd_addr_q    <= 13'h0000;
        end else begin
            reg_rvalid_q <= reg_rd;
            rd_addr_q    <= reg_addr;
            if (reg_rd) begin
                unique case (reg_addr)
                    `OFS_USER_PAT2_LOW:  reg_rdata_q <= user_pattern_two_q[7:0];
                    `OFS_USER_PAT2_HIGH: reg_rdata_q <= user_pattern_two_q[15:8];
                    `OFS_SIGNATURE_LOW:  reg_rdata_q <= {7'h00, signature_bit};
                    `OFS_OVERRANGE_OE:
                        reg_rdata_q <= {7'h00, chan_mask[0] ? overrange_oe_q[0]
                                                            : overrange_oe_q[1]};
                    `OFS_CHAN_SOURCE:
                        reg_rdata_q <= {7'h00, chan_mask[0] ? chan_source_q[0]
                                                            : chan_source_q[1]};
                    `OFS_DIV_SYNC_CTL:
                        reg_rdata_q <= {5'h00, next_only_q, div_en_q, master_q};
                    `OFS_MISC_USER_CTL:
                        reg_rdata_q <= {oe_pin_ctl_q, 3'h0, detect_en_q, run_osc_q,
                                        1'b0, pd_dis_q};
                    default:             reg_rdata_q <= 8'h00;
                endcase
            end
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    no_sync_unmastered_a: assert property (
        !$past(master_q) |-> !div_sync_pulse_q)
        else $error("sync pulse without master enable");
    sync_gate_pass_a: assert property (
        sync_edge && master_q && div_en_q |=> div_sync_pulse_q)
        else $error("gated sync pulse not passed");
    sync_gate_block_a: assert property (
        sync_edge && !div_en_q |=> !div_sync_pulse_q)
        else $error("sync pulse passed while gated off");
    oneshot_clear_a: assert property (
        sync_fire && next_only_q && !sync_wr |=> !div_en_q && master_q)
        else $error("divider sync enable not self-cleared");
    oneshot_once_a: assert property (
        (div_sync_pulse_q && $past(next_only_q)) ##1 (!sync_wr)[*8] |-> !div_sync_pulse_q)
        else $error("second sync pulse in one-shot mode");
    oe_pin_ignored_a: assert property (
        !oe_pin_ctl_q && !misc_wr |=> data_out_enable_q)
        else $error("output enable pin not ignored");
    oe_pin_follow_a: assert property (
        oe_pin_ctl_q && !misc_wr |=> data_out_enable_q == !$past(oe_sr_q[1]))
        else $error("outputs not following output enable pin");
    osc_forced_a: assert property (
        run_osc_q && !misc_wr |=> osc_run_q)
        else $error("oscillator not forced on");
    detect_off_a: assert property (
        !detect_en_q && !run_osc_q && !misc_wr |=> ##1 !osc_run_q)
        else $error("oscillator on with detector disabled");
    pulldown_ctl_a: assert property (
        !misc_wr |=> sdio_pulldown_en_q == !$past(pd_dis_q))
        else $error("pull-down does not follow disable bit");
    reset_default_a: assert property (
        $past(srst) |-> master_q && !div_en_q && !next_only_q && oe_pin_ctl_q
                        && detect_en_q && !run_osc_q && !pd_dis_q)
        else $error("register defaults wrong after reset");
    open_bits_zero_a: assert property (
        reg_rvalid_q && rd_addr_q == `OFS_DIV_SYNC_CTL |-> reg_rdata_q[7:3] == 5'h00)
        else $error("open sync control bits read nonzero");
    detect_drive_a: assert property (
        detect_en_q && low_rate_q && !misc_wr |=> osc_run_q)
        else $error("low rate detected but oscillator off");
    chan_reset_a: assert property (
        $past(srst) |-> user_pattern_two_q == 16'h0000 && overrange_oe_q == 2'h3
                        && chan_source_q == 2'h2)
        else $error("per-channel defaults wrong after reset");
endmodule // adc_sync_misc_control_regs
`default_nettype wire

// ### tb/host_model.sv
`default_nettype none
module host_model (
    input  wire logic                    sys_clk,   // bench clock
    input  wire logic                    rvalid,    // read data valid
    input  wire adc_ctl_pkg::reg_byte_t  rdata,     // read data
    output adc_ctl_pkg::reg_addr_t       reg_addr,  // address
    output logic                         reg_wr,    // write strobe
    output logic                         reg_rd,    // read strobe
    output adc_ctl_pkg::reg_byte_t       reg_wdata, // write data
    output adc_ctl_pkg::chan_mask_t      chan_mask  // channel index
);
    timeunit 1ns;
    timeprecision 1ns;
    import adc_ctl_pkg::*;
    initial begin
        reg_addr = 13'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
        chan_mask = 2'h1;
    end
    // idle lines flip so a stale address or data can never look valid
    task automatic idle();
        reg_wr = 1'b0; // strobes drop between accesses so the port stays quiet
        reg_rd = 1'b0;
        reg_addr = ~reg_addr;
        reg_wdata = ~reg_wdata;
    endtask
    task automatic wr(input reg_addr_t a, input reg_byte_t d, input chan_mask_t m);
        @(negedge sys_clk);
        reg_addr = a;
        reg_wdata = d;
        chan_mask = m;
        reg_wr = 1'b1;
        @(negedge sys_clk);
        idle();
    endtask
    task automatic rd(input reg_addr_t a, input chan_mask_t m, output reg_byte_t d);
        d = 8'hEE;
        @(negedge sys_clk);
        reg_addr = a;
        chan_mask = m;
        reg_rd = 1'b1;
        @(negedge sys_clk);
        idle();
        repeat (3) begin
            if (rvalid === 1'b1) d = rdata;
            @(negedge sys_clk);
        end
    endtask
endmodule // host_model
`default_nettype wire

// ### tb/tb.sv
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import adc_ctl_pkg::*;
    logic sys_clk, srst, sig, sync_pin, oe_n, enc, enc_run, wr, rd, rv, pls, doe, osc, pd;
    reg_addr_t   a;
    reg_byte_t   wd, rdat;
    chan_mask_t  m;
    logic [15:0] pat;
    logic [1:0]  ora_q, cs_q;
    int miscompares, n_tests, cyc, pulses, pat_lo, pat_hi, sync_r, misc_r;
    int ora[2], cs[2];
    logic [31:0] seed = 32'h524D43AA;

    adc_sync_misc_control_regs uut (.sys_clk(sys_clk), .srst(srst), .reg_addr(a),
        .reg_wr(wr), .reg_rd(rd), .reg_wdata(wd), .chan_mask(m), .reg_rdata_q(rdat),
        .reg_rvalid_q(rv), .signature_bit(sig), .sync_pin(sync_pin),
        .output_enable_pin_n(oe_n), .encode_tick(enc), .user_pattern_two_q(pat),
        .overrange_oe_q(ora_q), .chan_source_q(cs_q), .div_sync_pulse_q(pls),
        .data_out_enable_q(doe), .osc_run_q(osc), .sdio_pulldown_en_q(pd));
    host_model host (.sys_clk(sys_clk), .rvalid(rv), .rdata(rdat), .reg_addr(a),
        .reg_wr(wr), .reg_rd(rd), .reg_wdata(wd), .chan_mask(m));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(negedge sys_clk) if (enc_run) enc <= ~enc;
    always @(posedge sys_clk) begin
        cyc++;
        if (pls === 1'b1) pulses++;
        if (cyc == 5000) begin
            miscompares++;
            results();
        end
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic int mdl_rd(reg_addr_t ad, chan_mask_t mm);
        case (ad)
            13'h001B: return pat_lo;
            13'h001C: return pat_hi;
            13'h0024: return int'(sig);
            13'h002A: return mm[0] ? ora[0] : ora[1];
            13'h002E: return mm[0] ? cs[0] : cs[1];
            13'h0100: return sync_r;
            13'h0101: return misc_r;
            default: return 0;
        endcase
    endfunction
    // open bits are masked here, so a write of ones proves they stay zero
    task automatic mdl_wr(reg_addr_t ad, int d, chan_mask_t mm);
        case (ad)
            13'h001B: pat_lo = d;
            13'h001C: pat_hi = d;
            13'h002A: for (int c = 0; c < 2; c++) if (mm[c]) ora[c] = d % 2;
            13'h002E: for (int c = 0; c < 2; c++) if (mm[c]) cs[c] = d % 2;
            13'h0100: sync_r = d & 7;
            13'h0101: misc_r = d & 8'h8D;
            default: ;
        endcase
    endtask
    task automatic check(input string what, input logic [15:0] seen, input int exp);
        n_tests++;
        if (seen !== exp[15:0]) begin
            miscompares++;
            $display("ERROR %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic chk_outs();
        check("pattern", pat, pat_hi * 256 + pat_lo);
        check("overrange", ora_q, ora[1] * 2 + ora[0]);
        check("source", cs_q, cs[1] * 2 + cs[0]);
        check("pulldown", pd, 1 - misc_r % 2);
        check("osc", osc, misc_r / 4 % 2);
        check("out enable", doe, misc_r >= 128 ? int'(!oe_n) : 1);
    endtask
    task automatic sync_case(int ctl, int exp_n, int exp_reg);
        reg_byte_t d;
        host.wr(13'h0100, ctl[7:0], 2'h1);
        pulses = 0;
        repeat (2) begin
            @(negedge sys_clk);
            sync_pin = 1'b1;
            repeat (3) @(negedge sys_clk);
            sync_pin = 1'b0;
            repeat (8) @(negedge sys_clk);
        end
        check("sync pulses", pulses, exp_n);
        host.rd(13'h0100, 2'h1, d);
        check("sync ctl", d, exp_reg);
        sync_r = exp_reg;
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        reg_byte_t d;
        logic [31:0] r;
        static reg_addr_t al[8] = '{13'h001B, 13'h001C, 13'h0024, 13'h002A, 13'h002E,
                                    13'h0100, 13'h0101, 13'h0102};
        static int lr_m[5] = '{8'h08, 8'h00, 8'h04, 8'h08, 8'h01};
        static int lr_o[5] = '{1, 0, 1, 0, 0};
        srst = 1'b1;
        {sig, sync_pin, oe_n, enc, enc_run} = 5'b00001;
        ora = '{1, 1};
        cs = '{0, 1};
        {pat_lo, pat_hi, sync_r, misc_r} = {32'd0, 32'd0, 32'd1, 32'h88};
        repeat (4) @(negedge sys_clk);
        srst = 1'b0;
        for (int i = 0; i < 16; i++) begin
            host.rd(al[i / 2], 2'(i % 2 + 1), d);
            check("reset read", d, mdl_rd(al[i / 2], 2'(i % 2 + 1)));
        end
        chk_outs();
        $display("test reset done");
        for (int i = 0; i < 40; i++) begin
            r = xs();
            sig = r[20];
            host.wr(al[r[2:0]], r[15:8], r[17:16]);
            mdl_wr(al[r[2:0]], int'(r[15:8]), r[17:16]);
            host.rd(al[r[2:0]], r[19:18], d);
            check("reg read", d, mdl_rd(al[r[2:0]], r[19:18]));
            chk_outs();
        end
        $display("test registers done");
        sync_case(8'h06, 0, 8'h06);
        sync_case(8'h01, 0, 8'h01);
        sync_case(8'h03, 2, 8'h03);
        sync_case(8'h07, 1, 8'h05);
        $display("test sync done");
        for (int i = 0; i < 4; i++) begin
            misc_r = i[1] ? 8'h80 : 8'h00;
            host.wr(13'h0101, misc_r[7:0], 2'h1);
            oe_n = i[0];
            repeat (5) @(negedge sys_clk);
            check("out enable", doe, i[1] ? int'(!i[0]) : 1);
        end
        $display("test output enable done");
        // the encoder stops in the first rows so a whole detector window sees no edge
        for (int i = 0; i < 5; i++) begin
            enc_run = i > 2;
            misc_r = lr_m[i];
            host.wr(13'h0101, misc_r[7:0], 2'h1);
            repeat (250) @(negedge sys_clk);
            check("osc", osc, lr_o[i]);
            check("pulldown", pd, 1 - misc_r % 2);
        end
        $display("test oscillator done");
        results();
    end
endmodule // tb
`default_nettype wire
